// >>> bmad_pkg.sv
// Package: boot mode and address decode constants and types
package bmad_pkg;
  localparam int ADDR_W = 24;
  localparam logic [23:0] SRAM_LO = 24'h000000;
  localparam logic [23:0] SRAM_HI = 24'h01FFFF;
  localparam logic [23:0] SRAM_SHADOW_HI = 24'h000FFF;
  localparam logic [23:0] MIRROR_LO = 24'h100000;
  localparam logic [23:0] MIRROR_HI = 24'h11FFFF;
  localparam logic [23:0] SMALL_SRAM_MASK = 24'h001FFF;
  localparam logic [23:0] EPROM_LO = 24'h400000;
  localparam logic [23:0] EPROM_HI = 24'h5FFFFF;
  localparam logic [23:0] INTERNAL_LO = 24'h800000;
  localparam logic [23:0] INTERNAL_HI = 24'h809FFF;
  localparam logic [23:0] SERA_LO = 24'hA00000;
  localparam logic [23:0] SERA_HI = 24'hA0003F;
  localparam logic [23:0] SERB_LO = 24'hA00040;
  localparam logic [23:0] SERB_HI = 24'hA0007F;
  localparam logic [23:0] EXP_LO = 24'hFF0000;
  localparam logic [23:0] EXP_HI = 24'hFFFFFF;
  localparam logic [1:0] SERIAL_WAITS = 2'h3;
  localparam logic [2:0] MODE_SWITCH_CYCLES = 3'h4;
  // Jumper pattern {E,D,C,B,A}, 1 = installed
  localparam logic [4:0] JP_SRAM_START = 5'h01;
  localparam logic [4:0] JP_EPROM_BOOT = 5'h12;
  localparam logic [4:0] JP_SERIAL_BOOT = 5'h1A;
  localparam logic [4:0] JP_EPROM_THEN_PROC = 5'h14;
  localparam logic [4:0] JP_SERIAL_THEN_PROC = 5'h1C;
  typedef enum logic [5:0] {
    BMAD_SRAM_START = 6'h01,
    BMAD_EPROM_BOOT = 6'h02,
    BMAD_SERIAL_BOOT = 6'h04,
    BMAD_EPROM_THEN_PROC = 6'h08,
    BMAD_SERIAL_THEN_PROC = 6'h10,
    BMAD_RESERVED = 6'h20
  } bmad_sel_t;
  typedef struct packed {
    logic sram;
    logic eprom;
    logic serial_a;
    logic serial_b;
    logic expansion;
  } bmad_cs_t;
endpackage : bmad_pkg

// >>> bmad_wait_gen.sv
// Wait-state counter producing external ready for one access
`timescale 1ns/1ns
module bmad_wait_gen
#(
  parameter int CNT_W = 2
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic access,
  input wire logic [CNT_W-1:0] waits,
  input wire logic ext_ready,
  output logic ready
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!access)
      cnt_next = '0;
    else if (cnt_reg != waits)
      cnt_next = cnt_reg + 1'b1;
  end
  // First access cycle is count zero, so waits equals inserted wait states
  assign ready = !access || (cnt_reg == waits && ext_ready);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : bmad_wait_gen

// >>> bmad_top.sv
// Boot-mode selection, mode switch and external address decode
`timescale 1ns/1ns
module bmad_top
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] boot_select_jumpers,
  input wire logic sram_size_jumper,
  input wire logic interrupt_acknowledge_instruction,
  input wire logic [bmad_pkg::ADDR_W-1:0] addr,
  input wire logic strobe,
  input wire logic rw,
  input wire logic expansion_ready_in,
  input wire logic [1:0] expansion_waits,
  input wire logic [3:0] int_req_in,
  output logic [3:0] int_req_out,
  output logic micro_processor_mode,
  output bmad_pkg::bmad_sel_t boot_sel,
  output bmad_pkg::bmad_cs_t chip_sel,
  output logic ready
);
  import bmad_pkg::*;

  logic [4:0] jmp_s1_reg;
  logic [4:0] jmp_s2_reg;
  logic [1:0] exp_rdy_sync_reg;
  logic [1:0] size_sync_reg;
  logic [3:0] int_s1_reg;
  logic [3:0] int_s2_reg;
  bmad_sel_t sel_reg;
  bmad_sel_t sel_next;
  bmad_sel_t decoded;
  logic mp_reg;
  logic mp_next;
  logic int_en_reg;
  logic int_en_next;
  logic [2:0] sw_cnt_reg;
  logic [2:0] sw_cnt_next;
  logic sw_pend_reg;
  logic sw_pend_next;
  logic in_reset_reg;
  bmad_cs_t cs_next;
  logic [1:0] waits_c;
  logic wait_access;
  logic wait_ready;
  logic exp_ready_c;
  logic is_then_proc;
  logic [23:0] sram_off;

  // Jumpers keep sampling through reset so the selection is settled at release
  always_ff @(posedge clk)
  begin
    jmp_s1_reg <= boot_select_jumpers;
    jmp_s2_reg <= jmp_s1_reg;
  end

  // Pin synchronisers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      exp_rdy_sync_reg <= 2'h0;
      size_sync_reg <= 2'h0;
      int_s1_reg <= 4'h0;
      int_s2_reg <= 4'h0;
    end
    else
    begin
      exp_rdy_sync_reg <= {exp_rdy_sync_reg[0], expansion_ready_in};
      size_sync_reg <= {size_sync_reg[0], sram_size_jumper};
      int_s1_reg <= int_req_in;
      int_s2_reg <= int_s1_reg;
    end
  end

  always_comb
  begin
    case (jmp_s2_reg)
      JP_SRAM_START: decoded = BMAD_SRAM_START;
      JP_EPROM_BOOT: decoded = BMAD_EPROM_BOOT;
      JP_SERIAL_BOOT: decoded = BMAD_SERIAL_BOOT;
      JP_EPROM_THEN_PROC: decoded = BMAD_EPROM_THEN_PROC;
      JP_SERIAL_THEN_PROC: decoded = BMAD_SERIAL_THEN_PROC;
      default: decoded = BMAD_RESERVED;
    endcase
  end

  assign is_then_proc = (sel_reg == BMAD_EPROM_THEN_PROC) || (sel_reg == BMAD_SERIAL_THEN_PROC);

  // Mode state: catch jumpers at the first edge after release, then hold
  always_comb
  begin
    sel_next = sel_reg;
    mp_next = mp_reg;
    int_en_next = int_en_reg;
    sw_cnt_next = sw_cnt_reg;
    sw_pend_next = sw_pend_reg;
    if (in_reset_reg)
    begin
      sel_next = decoded;
      mp_next = (decoded == BMAD_SRAM_START) || (decoded == BMAD_RESERVED);
      int_en_next = mp_next;
      sw_cnt_next = 3'h0;
      sw_pend_next = 1'b0;
    end
    else
    begin
      if (interrupt_acknowledge_instruction && !int_en_reg)
      begin
        int_en_next = 1'b1;
        if (is_then_proc)
        begin
          sw_pend_next = 1'b1;
          sw_cnt_next = 3'h1;
        end
      end
      if (sw_pend_reg)
      begin
        if (sw_cnt_reg == MODE_SWITCH_CYCLES)
        begin
          mp_next = 1'b1;
          sw_pend_next = 1'b0;
        end
        else
          sw_cnt_next = sw_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_reset_reg <= 1'b1;
      sel_reg <= BMAD_RESERVED;
      mp_reg <= 1'b1;
      int_en_reg <= 1'b0;
      sw_cnt_reg <= 3'h0;
      sw_pend_reg <= 1'b0;
    end
    else
    begin
      in_reset_reg <= 1'b0;
      sel_reg <= sel_next;
      mp_reg <= mp_next;
      int_en_reg <= int_en_next;
      sw_cnt_reg <= sw_cnt_next;
      sw_pend_reg <= sw_pend_next;
    end
  end

  // Small chips decode only the low rows; larger ones the full bank
  assign sram_off = size_sync_reg[1] ? (addr & SMALL_SRAM_MASK) : addr;

  always_comb
  begin
    cs_next = '0;
    waits_c = 2'h0;
    wait_access = 1'b0;
    if (!strobe)
    begin
      cs_next = '0;
    end
    else if (addr >= MIRROR_LO && addr <= MIRROR_HI)
      cs_next.sram = 1'b1;
    else if (addr >= SRAM_LO && addr <= SRAM_HI)
      cs_next.sram = mp_reg || (sram_off > SRAM_SHADOW_HI && addr > SRAM_SHADOW_HI);
    else if (addr >= EPROM_LO && addr <= EPROM_HI)
      cs_next.eprom = rw;
    else if (addr >= INTERNAL_LO && addr <= INTERNAL_HI)
      cs_next = '0;
    else if (addr >= SERA_LO && addr <= SERA_HI)
    begin
      cs_next.serial_a = 1'b1;
      waits_c = SERIAL_WAITS;
      wait_access = 1'b1;
    end
    else if (addr >= SERB_LO && addr <= SERB_HI)
    begin
      cs_next.serial_b = 1'b1;
      waits_c = SERIAL_WAITS;
      wait_access = 1'b1;
    end
    else if (addr >= EXP_LO && addr <= EXP_HI)
    begin
      cs_next.expansion = 1'b1;
      waits_c = expansion_waits;
      wait_access = 1'b1;
    end
  end

  assign exp_ready_c = cs_next.expansion ? exp_rdy_sync_reg[1] : 1'b1;

  bmad_wait_gen #(.CNT_W(2)) u_wait
  (
    .clk(clk),
    .reset_n(reset_n),
    .access(wait_access),
    .waits(waits_c),
    .ext_ready(exp_ready_c),
    .ready(wait_ready)
  );

  assign chip_sel = cs_next;
  assign ready = wait_ready;
  assign micro_processor_mode = mp_reg;
  assign boot_sel = sel_reg;
  assign int_req_out = int_en_reg ? int_s2_reg : 4'h0;

  property p_mode_switch;
    @(posedge clk) disable iff (!reset_n)
    (interrupt_acknowledge_instruction && !int_en_reg && is_then_proc && !in_reset_reg)
      |-> !mp_reg [*5] ##1 mp_reg;
  endproperty
  a_mode_switch: assert property (p_mode_switch) else $error("mode switch timing");

  property p_int_gate;
    @(posedge clk) disable iff (!reset_n)
    !int_en_reg |-> int_req_out == 4'h0;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupts not gated");

  property p_sram_start_mp;
    @(posedge clk) disable iff (!reset_n)
    (!in_reset_reg && sel_reg == BMAD_SRAM_START) |-> mp_reg;
  endproperty
  a_sram_start_mp: assert property (p_sram_start_mp) else $error("sram start not mp");

  property p_boot_mc;
    @(posedge clk) disable iff (!reset_n)
    ($fell(in_reset_reg) && sel_reg != BMAD_SRAM_START && sel_reg != BMAD_RESERVED) |-> !mp_reg;
  endproperty
  a_boot_mc: assert property (p_boot_mc) else $error("boot not mc");

  property p_sel_hold;
    @(posedge clk) disable iff (!reset_n)
    !in_reset_reg |=> $stable(sel_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed");

  property p_internal;
    @(posedge clk) disable iff (!reset_n)
    (strobe && addr >= INTERNAL_LO && addr <= INTERNAL_HI) |-> chip_sel == '0 && ready;
  endproperty
  a_internal: assert property (p_internal) else $error("internal range selected");

  sequence s_serial_wait;
    !ready [*3] ##1 ready;
  endsequence
  property p_serial_ws;
    @(posedge clk) disable iff (!reset_n)
    (strobe && (addr >= SERA_LO && addr <= SERB_HI) && !$past(wait_access)) |-> s_serial_wait;
  endproperty
  a_serial_ws: assert property (p_serial_ws) else $error("serial wait count");

  property p_eprom_ro;
    @(posedge clk) disable iff (!reset_n)
    (strobe && !rw) |-> !chip_sel.eprom;
  endproperty
  a_eprom_ro: assert property (p_eprom_ro) else $error("eprom write selected");

  property p_shadow;
    @(posedge clk) disable iff (!reset_n)
    (strobe && !mp_reg && addr <= SRAM_SHADOW_HI) |-> !chip_sel.sram;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadowed sram selected");

  property p_mirror;
    @(posedge clk) disable iff (!reset_n)
    (strobe && addr >= MIRROR_LO && addr <= MIRROR_HI) |-> chip_sel.sram && ready;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror not selected");

  property p_sram_zero_ws;
    @(posedge clk) disable iff (!reset_n)
    (strobe && chip_sel.sram) |-> ready;
  endproperty
  a_sram_zero_ws: assert property (p_sram_zero_ws) else $error("sram access waited");

  property p_exp_sel;
    @(posedge clk) disable iff (!reset_n)
    (strobe && addr >= EXP_LO && addr <= EXP_HI) |-> chip_sel.expansion;
  endproperty
  a_exp_sel: assert property (p_exp_sel) else $error("expansion not selected");

  property p_exp_hold;
    @(posedge clk) disable iff (!reset_n)
    (chip_sel.expansion && !exp_rdy_sync_reg[1]) |-> !ready;
  endproperty
  a_exp_hold: assert property (p_exp_hold) else $error("expansion not held off");

  property p_gate_open;
    @(posedge clk) disable iff (!reset_n)
    (interrupt_acknowledge_instruction && !in_reset_reg) |=> int_en_reg;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("interrupts not opened");

  property p_decode;
    @(posedge clk) disable iff (!reset_n)
    (in_reset_reg && jmp_s2_reg == JP_EPROM_THEN_PROC) |=> sel_reg == BMAD_EPROM_THEN_PROC;
  endproperty
  a_decode: assert property (p_decode) else $error("jumper decode wrong");

  property p_then_proc_mc;
    @(posedge clk) disable iff (!reset_n)
    (!in_reset_reg && is_then_proc && !int_en_reg) |-> !mp_reg;
  endproperty
  a_then_proc_mc: assert property (p_then_proc_mc) else $error("early mode switch");
endmodule : bmad_top

// >>> bmad_cpu_model.sv
// Processor external bus model: accesses and acknowledge pulses
`timescale 1ns/1ns
module bmad_cpu_model
(
  input wire logic clk,
  input wire logic ready,
  input wire bmad_pkg::bmad_cs_t chip_sel,
  output logic [bmad_pkg::ADDR_W-1:0] addr,
  output logic strobe,
  output logic rw,
  output logic ack
);
  import bmad_pkg::*;
  // Primary bus control values: boot setting and run-time setting
  localparam logic [31:0] BUS_CTRL_BOOT = 32'h000006F8;
  localparam logic [31:0] BUS_CTRL_RUN = 32'h00000400;
  // Software waits of the boot setting, combined with external ready
  localparam int BOOT_SW_WAITS = 7;
  logic [31:0] bus_ctrl;
  initial
  begin
    bus_ctrl = BUS_CTRL_RUN;
    addr = 24'h000000;
    strobe = 1'h0;
    rw = 1'h1;
    ack = 1'h0;
  end
  task automatic load_bus_ctrl(input logic boot);
    bus_ctrl = boot ? BUS_CTRL_BOOT : BUS_CTRL_RUN;
  endtask : load_bus_ctrl
  task automatic access(input logic [23:0] a, input logic r, output logic [4:0] cs,
    output int n);
    int sw_w;
    n = 0;
    sw_w = (bus_ctrl == BUS_CTRL_BOOT) ? BOOT_SW_WAITS : 0;
    @(posedge clk);
    #10;
    addr = a;
    rw = r;
    strobe = 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (n == 1)
        cs = chip_sel;
    end
    while ((ready !== 1'h1 || n <= sw_w) && n < 20);
    #10;
    strobe = 1'h0;
    // Released bus shows no stale address
    addr = ~a;
    rw = ~r;
  endtask : access
  // Issued only once the bootloader has taken its formatted image
  task automatic acknowledge();
    @(posedge clk);
    #10;
    addr = 24'h001000;
    ack = 1'h1;
    @(posedge clk);
    #10;
    ack = 1'h0;
    // User software now runs with the run-time bus setting
    bus_ctrl = BUS_CTRL_RUN;
  endtask : acknowledge
endmodule : bmad_cpu_model

// >>> boot_mode_and_address_decode_test.sv
// Self-checking bench for boot mode and address decode
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module boot_mode_and_address_decode_test;
  import bmad_pkg::*;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [4:0] jumpers = 5'h01;
  logic size_j = 1'h0;
  logic exp_rdy = 1'h1;
  logic [1:0] exp_w = 2'h0;
  logic [3:0] irq = 4'hA;
  logic [23:0] addr;
  logic strobe;
  logic rw;
  logic ack;
  logic [3:0] irq_out;
  logic mode;
  bmad_sel_t boot_sel;
  bmad_cs_t chip_sel;
  logic ready;
  int err_count = 0;
  int num_checks = 0;
  logic [4:0] cs;
  int n;
  logic [4:0] jp [5] = '{JP_SRAM_START, JP_EPROM_BOOT, JP_SERIAL_BOOT, JP_EPROM_THEN_PROC,
    JP_SERIAL_THEN_PROC};
  bmad_sel_t sel [5] = '{BMAD_SRAM_START, BMAD_EPROM_BOOT, BMAD_SERIAL_BOOT,
    BMAD_EPROM_THEN_PROC, BMAD_SERIAL_THEN_PROC};
  logic [23:0] t_a [12] = '{24'h400000, 24'h5FFFFF, 24'h400000, 24'h800000, 24'h809FFF,
    24'hA00000, 24'hA0003F, 24'hA00040, 24'hA0007F, 24'h200000, 24'h01FFFF, 24'h11FFFF};
  logic t_r [12] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  logic [4:0] t_cs [12] = '{5'h08, 5'h08, 5'h00, 5'h00, 5'h00, 5'h04, 5'h04, 5'h02, 5'h02,
    5'h00, 5'h10, 5'h10};
  always #50 clk = ~clk;
  bmad_top i_dut
  (
    .clk(clk),
    .reset_n(reset_n),
    .boot_select_jumpers(jumpers),
    .sram_size_jumper(size_j),
    .interrupt_acknowledge_instruction(ack),
    .addr(addr),
    .strobe(strobe),
    .rw(rw),
    .expansion_ready_in(exp_rdy),
    .expansion_waits(exp_w),
    .int_req_in(irq),
    .int_req_out(irq_out),
    .micro_processor_mode(mode),
    .boot_sel(boot_sel),
    .chip_sel(chip_sel),
    .ready(ready)
  );
  bmad_cpu_model i_cpu
  (
    .clk(clk),
    .ready(ready),
    .chip_sel(chip_sel),
    .addr(addr),
    .strobe(strobe),
    .rw(rw),
    .ack(ack)
  );
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : cyc
  task automatic reset_to(input logic [4:0] j, input logic s);
    cyc(1);
    reset_n = 1'h0;
    jumpers = j;
    size_j = s;
    cyc(16);
    reset_n = 1'h1;
    cyc(2);
  endtask : reset_to
  task automatic xfer(input logic [23:0] a, input logic r, input logic [4:0] ecs, input int en);
    i_cpu.access(a, r, cs, n);
    `CHK("chip_sel", ecs, cs)
    `CHK("cycles", en, n)
  endtask : xfer
  task automatic conclude();
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      reset_to(jp[i], 1'h0);
      i_cpu.load_bus_ctrl(i != 0);
      `CHK("boot_sel", sel[i], boot_sel)
      `CHK("mode", i == 0, mode)
      cyc(8);
      `CHK("int_out", (i == 0) ? 4'hA : 4'h0, irq_out)
      xfer(24'h000100, 1'h1, (i == 0) ? 5'h10 : 5'h00, (i == 0) ? 1 : 8);
      xfer(24'h100100, 1'h0, 5'h10, (i == 0) ? 1 : 8);
      xfer(24'h001000, 1'h1, 5'h10, (i == 0) ? 1 : 8);
      i_cpu.acknowledge();
      `CHK("mode", i == 0, mode)
      cyc(3);
      `CHK("mode", i == 0, mode)
      cyc(1);
      `CHK("mode", i != 1 && i != 2, mode)
      cyc(8);
      `CHK("int_out", 4'hA, irq_out)
      xfer(24'h000100, 1'h0, (i == 1 || i == 2) ? 5'h00 : 5'h10, 1);
    end
    for (int i = 0; i < 12; i++)
      xfer(t_a[i], t_r[i], t_cs[i], (t_cs[i][2] | t_cs[i][1]) ? SERIAL_WAITS + 1 : 1);
    for (int w = 0; w < 4; w++)
    begin
      exp_w = w[1:0];
      xfer(24'hFF0000 + w * 24'h00FFFF / 3, w[0], 5'h01, w + 1);
    end
    exp_w = 2'h1;
    exp_rdy = 1'h0;
    fork
      i_cpu.access(24'hFF8000, 1'h1, cs, n);
      begin
        cyc(8);
        exp_rdy = 1'h1;
      end
    join
    `CHK("stall", 1'h1, n >= 7 && n <= 14)
    reset_to(JP_EPROM_BOOT, 1'h1);
    xfer(24'h002100, 1'h1, 5'h00, 1);
    reset_to(JP_EPROM_BOOT, 1'h0);
    xfer(24'h002100, 1'h1, 5'h10, 1);
    conclude();
  end
  initial
  begin
    #3000000;
    err_count++;
    conclude();
  end
endmodule : boot_mode_and_address_decode_test
